// >>> verilog/ulbf_map.svh
`ifndef ULBF_MAP_SVH
`define ULBF_MAP_SVH

`define ULBF_PAR_NONE 2'h0
`define ULBF_PAR_ZERO 2'h1
`define ULBF_PAR_ODD 2'h2
`define ULBF_PAR_EVEN 2'h3

`define ULBF_CHAR8_BITS 5'h08
`define ULBF_CHAR7_BITS 5'h07
`define ULBF_STOP1_BITS 5'h01
`define ULBF_STOP2_BITS 5'h02
`define ULBF_BRK_TX_BASE 5'h0D
`define ULBF_BRK_RX_VALID 5'h0B
`define ULBF_DATA_INIT 8'hFF
`define ULBF_DIV_MIN 12'h001

`endif

// >>> verilog/ulbf_pkg.sv
package ulbf_pkg;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} ulbf_tx_e;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK, RX_WAITHI} ulbf_rx_e;

  typedef struct packed {
    logic [11:0] cnt;
  } ulbf_timer_s;

  typedef struct packed {
    logic sync1;
    logic sync2;
    ulbf_tx_e tx_st;
    ulbf_rx_e rx_st;
    logic [7:0] tx_data;
    logic tx_pend;
    logic brk_pend;
    logic [7:0] tx_shift;
    logic [4:0] tx_cnt;
    logic tx_par;
    logic tx_lvl;
    logic tx_line;
    logic brk_tx_act;
    logic [7:0] rx_shift;
    logic [4:0] rx_cnt;
    logic rx_par_bit;
    logic all_low;
    logic [4:0] low_cnt;
    logic [7:0] rx_data;
    logic rx_full;
    logic brk_rx_act;
    logic brk_ok;
    logic ovr;
    logic perr;
    logic ferr;
    logic tx_irq;
    logic rx_irq;
    logic st_irq;
  } ulbf_state_s;

endpackage

// >>> verilog/ulbf_bit_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ulbf_map.svh"

module ulbf_bit_timer (
  input wire logic clock,
  input wire logic rst,
  input wire logic restart,
  input wire logic half,
  input wire logic [11:0] divisor,
  output logic tick
);
  ulbf_pkg::ulbf_timer_s st_r;
  ulbf_pkg::ulbf_timer_s st_nxt;
  logic [11:0] full_load;
  logic [11:0] half_load;

  // A divisor of zero would stall the line, so it behaves as one.
  assign full_load = (divisor < `ULBF_DIV_MIN) ? `ULBF_DIV_MIN : divisor;
  assign half_load = ((divisor >> 1) < `ULBF_DIV_MIN) ? `ULBF_DIV_MIN : (divisor >> 1);
  // The tick is not gated by restart, which keeps the core free of a loop.
  assign tick = (st_r.cnt == `ULBF_DIV_MIN);

  always_comb begin
    st_nxt = st_r;
    if (restart) begin
      st_nxt.cnt = half ? half_load : full_load;
    end else if (tick) begin
      st_nxt.cnt = full_load;
    end else begin
      st_nxt.cnt = st_r.cnt - `ULBF_DIV_MIN;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

`default_nettype wire

// >>> verilog/ulbf_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "ulbf_map.svh"

module ulbf_core (
  input wire logic clock,
  input wire logic rst,
  input wire logic power_on,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic char_len_sel,
  input wire logic [1:0] parity_sel,
  input wire logic stop_len_sel,
  input wire logic bit_order_sel,
  input wire logic tx_level_invert,
  input wire logic rx_level_invert,
  input wire logic [2:0] break_len_sel,
  input wire logic [11:0] baud_divisor,
  input wire logic tx_irq_timing,
  input wire logic break_rx_mode,
  input wire logic break_tx_trigger,
  input wire logic break_rx_trigger,
  input wire logic break_ok_clear,
  input wire logic err_clear,
  input wire logic tx_data_wr,
  input wire logic [7:0] tx_data_in,
  input wire logic rx_data_read,
  input wire logic rx_line,
  output logic tx_line,
  output logic [7:0] rx_data_reg,
  output logic break_tx_active,
  output logic break_rx_active,
  output logic break_rx_ok_flag,
  output logic overrun_flag,
  output logic parity_err_flag,
  output logic framing_err_flag,
  output logic tx_irq,
  output logic rx_irq,
  output logic status_irq
);
  ulbf_pkg::ulbf_state_s st_r;
  ulbf_pkg::ulbf_state_s st_nxt;
  logic tx_tick;
  logic rx_tick;
  logic tx_restart;
  logic rx_restart;
  logic rx_half;
  logic tx_on;
  logic rx_on;
  logic rx_bit;
  logic brk_valid;
  logic [7:0] rx_word;
  logic [7:0] tx_word;

  // Parity bit for a character whose unused bit is already zero.
  function automatic logic par_bit(input logic [1:0] sel, input logic [7:0] d);
    logic r;
    r = 1'b0;
    if (sel == `ULBF_PAR_EVEN) begin
      r = ^d;
    end else if (sel == `ULBF_PAR_ODD) begin
      r = ~^d;
    end
    return r;
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7 - i];
    end
    return r;
  endfunction

  function automatic logic [4:0] char_bits(input logic clen);
    return clen ? `ULBF_CHAR8_BITS : `ULBF_CHAR7_BITS;
  endfunction

  ulbf_bit_timer u_tx_timer (
    .clock(clock),
    .rst(rst),
    .restart(tx_restart),
    .half(1'b0),
    .divisor(baud_divisor),
    .tick(tx_tick)
  );

  ulbf_bit_timer u_rx_timer (
    .clock(clock),
    .rst(rst),
    .restart(rx_restart),
    .half(rx_half),
    .divisor(baud_divisor),
    .tick(rx_tick)
  );

  assign tx_on = power_on & tx_enable;
  assign rx_on = power_on & rx_enable;
  assign rx_bit = st_r.sync2 ^ rx_level_invert;

  // Seven-bit characters are zero-filled on the side the bit order leaves unused.
  always_comb begin
    if (char_len_sel) begin
      tx_word = st_r.tx_data;
      rx_word = st_r.rx_shift;
    end else if (bit_order_sel) begin
      tx_word = {1'b0, st_r.tx_data[6:0]};
      rx_word = {1'b0, st_r.rx_shift[7:1]};
    end else begin
      tx_word = {st_r.tx_data[7:1], 1'b0};
      rx_word = {st_r.rx_shift[6:0], 1'b0};
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.tx_irq = 1'b0;
    st_nxt.rx_irq = 1'b0;
    st_nxt.st_irq = 1'b0;
    tx_restart = 1'b0;
    rx_restart = 1'b0;
    rx_half = 1'b0;
    brk_valid = 1'b0;
    st_nxt.sync1 = rx_line;
    st_nxt.sync2 = st_r.sync1;

    if (tx_data_wr) begin
      st_nxt.tx_data = tx_data_in;
      st_nxt.tx_pend = tx_on;
    end
    if (break_tx_trigger && tx_on) begin
      st_nxt.brk_pend = 1'b1;
    end

    // Transmitter; it never looks at the receiver, so both run at once.
    case (st_r.tx_st)
      ulbf_pkg::TX_IDLE: begin
        // A waiting data byte goes out before a waiting break.
        if (st_r.tx_pend) begin
          st_nxt.tx_pend = 1'b0;
          st_nxt.tx_shift = bit_order_sel ? tx_word : rev8(tx_word);
          st_nxt.tx_par = par_bit(parity_sel, tx_word);
          st_nxt.tx_lvl = 1'b0;
          st_nxt.tx_st = ulbf_pkg::TX_START;
          st_nxt.tx_irq = ~tx_irq_timing;
          tx_restart = 1'b1;
        end else if (st_r.brk_pend) begin
          st_nxt.brk_pend = 1'b0;
          st_nxt.brk_tx_act = 1'b1;
          st_nxt.tx_cnt = `ULBF_BRK_TX_BASE + {2'h0, break_len_sel};
          st_nxt.tx_lvl = 1'b0;
          st_nxt.tx_st = ulbf_pkg::TX_BRK;
          st_nxt.tx_irq = ~tx_irq_timing;
          tx_restart = 1'b1;
        end
      end
      ulbf_pkg::TX_START: begin
        if (tx_tick) begin
          st_nxt.tx_cnt = char_bits(char_len_sel);
          st_nxt.tx_lvl = st_r.tx_shift[0];
          st_nxt.tx_st = ulbf_pkg::TX_DATA;
        end
      end
      ulbf_pkg::TX_DATA: begin
        if (tx_tick) begin
          st_nxt.tx_shift = st_r.tx_shift >> 1;
          st_nxt.tx_cnt = st_r.tx_cnt - 5'h01;
          st_nxt.tx_lvl = st_r.tx_shift[1];
          if (st_r.tx_cnt == 5'h01) begin
            if (parity_sel == `ULBF_PAR_NONE) begin
              st_nxt.tx_lvl = 1'b1;
              st_nxt.tx_cnt = stop_len_sel ? `ULBF_STOP2_BITS : `ULBF_STOP1_BITS;
              st_nxt.tx_st = ulbf_pkg::TX_STOP;
            end else begin
              st_nxt.tx_lvl = st_r.tx_par;
              st_nxt.tx_st = ulbf_pkg::TX_PAR;
            end
          end
        end
      end
      ulbf_pkg::TX_PAR: begin
        if (tx_tick) begin
          st_nxt.tx_lvl = 1'b1;
          st_nxt.tx_cnt = stop_len_sel ? `ULBF_STOP2_BITS : `ULBF_STOP1_BITS;
          st_nxt.tx_st = ulbf_pkg::TX_STOP;
        end
      end
      ulbf_pkg::TX_STOP: begin
        if (tx_tick) begin
          st_nxt.tx_cnt = st_r.tx_cnt - 5'h01;
          if (st_r.tx_cnt == 5'h01) begin
            st_nxt.tx_irq = tx_irq_timing;
            st_nxt.tx_st = ulbf_pkg::TX_IDLE;
          end
        end
      end
      ulbf_pkg::TX_BRK: begin
        if (tx_tick) begin
          st_nxt.tx_cnt = st_r.tx_cnt - 5'h01;
          if (st_r.tx_cnt == 5'h01) begin
            st_nxt.tx_lvl = 1'b1;
            st_nxt.brk_tx_act = 1'b0;
            st_nxt.tx_irq = tx_irq_timing;
            st_nxt.tx_st = ulbf_pkg::TX_IDLE;
          end
        end
      end
      default: st_nxt.tx_st = ulbf_pkg::TX_IDLE;
    endcase

    if (!tx_on) begin
      st_nxt.tx_st = ulbf_pkg::TX_IDLE;
      st_nxt.tx_pend = 1'b0;
      st_nxt.brk_pend = 1'b0;
      st_nxt.brk_tx_act = 1'b0;
      st_nxt.tx_lvl = 1'b1;
      st_nxt.tx_irq = 1'b0;
    end
    st_nxt.tx_line = st_nxt.tx_lvl ^ tx_level_invert;

    // Clears come first so that a same-cycle event still sets its flag.
    if (break_ok_clear) begin
      st_nxt.brk_ok = 1'b0;
    end
    if (err_clear) begin
      st_nxt.ovr = 1'b0;
      st_nxt.perr = 1'b0;
      st_nxt.ferr = 1'b0;
    end
    if (rx_data_read) begin
      st_nxt.rx_full = 1'b0;
    end

    case (st_r.rx_st)
      ulbf_pkg::RX_IDLE: begin
        if (rx_on && !rx_bit) begin
          st_nxt.rx_st = ulbf_pkg::RX_START;
          rx_restart = 1'b1;
          rx_half = 1'b1;
        end
      end
      ulbf_pkg::RX_START: begin
        if (rx_tick) begin
          if (rx_bit) begin
            st_nxt.rx_st = ulbf_pkg::RX_IDLE;
          end else begin
            st_nxt.low_cnt = 5'h01;
            st_nxt.all_low = 1'b1;
            st_nxt.rx_shift = '0;
            st_nxt.rx_par_bit = 1'b0;
            st_nxt.rx_cnt = char_bits(char_len_sel);
            st_nxt.rx_st = st_r.brk_rx_act ? ulbf_pkg::RX_BRK : ulbf_pkg::RX_DATA;
          end
        end
      end
      ulbf_pkg::RX_DATA: begin
        if (rx_tick) begin
          st_nxt.rx_shift = bit_order_sel ? {rx_bit, st_r.rx_shift[7:1]}
                                          : {st_r.rx_shift[6:0], rx_bit};
          st_nxt.all_low = st_r.all_low & ~rx_bit;
          st_nxt.low_cnt = st_r.low_cnt + 5'h01;
          st_nxt.rx_cnt = st_r.rx_cnt - 5'h01;
          if (st_r.rx_cnt == 5'h01) begin
            st_nxt.rx_st = (parity_sel == `ULBF_PAR_NONE) ? ulbf_pkg::RX_STOP
                                                         : ulbf_pkg::RX_PAR;
          end
        end
      end
      ulbf_pkg::RX_PAR: begin
        if (rx_tick) begin
          st_nxt.rx_par_bit = rx_bit;
          st_nxt.all_low = st_r.all_low & ~rx_bit;
          st_nxt.low_cnt = st_r.low_cnt + 5'h01;
          st_nxt.rx_st = ulbf_pkg::RX_STOP;
        end
      end
      ulbf_pkg::RX_STOP: begin
        if (rx_tick) begin
          // An all-low frame in anytime mode turns into a break candidate.
          if (break_rx_mode && st_r.all_low && !rx_bit) begin
            st_nxt.low_cnt = st_r.low_cnt + 5'h01;
            if (st_nxt.low_cnt >= `ULBF_BRK_RX_VALID) begin
              brk_valid = 1'b1;
            end else begin
              st_nxt.rx_st = ulbf_pkg::RX_BRK;
            end
          end else begin
            st_nxt.rx_st = ulbf_pkg::RX_IDLE;
            st_nxt.ferr = st_r.ferr | ~rx_bit;
            st_nxt.perr = st_r.perr | ((parity_sel != `ULBF_PAR_NONE)
                                       && (st_r.rx_par_bit != par_bit(parity_sel, rx_word)));
            st_nxt.ovr = st_r.ovr | st_r.rx_full;
            if (!st_r.rx_full) begin
              st_nxt.rx_data = rx_word;
              st_nxt.rx_full = 1'b1;
            end
            if (st_r.rx_full || !rx_bit || ((parity_sel != `ULBF_PAR_NONE)
                && (st_r.rx_par_bit != par_bit(parity_sel, rx_word)))) begin
              st_nxt.st_irq = 1'b1;
            end else begin
              st_nxt.rx_irq = 1'b1;
            end
          end
        end
      end
      ulbf_pkg::RX_BRK: begin
        // No shift, no error flags and no data transfer while counting.
        if (rx_tick) begin
          if (rx_bit) begin
            st_nxt.rx_st = ulbf_pkg::RX_IDLE;
          end else begin
            st_nxt.low_cnt = st_r.low_cnt + 5'h01;
            if (st_nxt.low_cnt >= `ULBF_BRK_RX_VALID) begin
              brk_valid = 1'b1;
            end
          end
        end
      end
      ulbf_pkg::RX_WAITHI: begin
        // The rest of the break must not read as a new start bit.
        if (rx_bit) begin
          st_nxt.rx_st = ulbf_pkg::RX_IDLE;
        end
      end
      default: st_nxt.rx_st = ulbf_pkg::RX_IDLE;
    endcase

    if (brk_valid && rx_on) begin
      st_nxt.rx_st = ulbf_pkg::RX_WAITHI;
      st_nxt.brk_rx_act = 1'b0;
      if (break_rx_mode) begin
        st_nxt.st_irq = 1'b1;
        st_nxt.brk_ok = 1'b1;
      end else begin
        st_nxt.rx_irq = 1'b1;
      end
    end

    if (!rx_on) begin
      st_nxt.rx_st = ulbf_pkg::RX_IDLE;
      st_nxt.brk_rx_act = 1'b0;
      st_nxt.rx_irq = 1'b0;
      st_nxt.st_irq = 1'b0;
    end else if (break_rx_trigger) begin
      st_nxt.brk_rx_act = 1'b1;
    end
    if (!power_on) begin
      st_nxt.rx_data = `ULBF_DATA_INIT;
      st_nxt.rx_full = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
      st_r.sync1 <= 1'b1;
      st_r.sync2 <= 1'b1;
      st_r.tx_st <= ulbf_pkg::TX_IDLE;
      st_r.rx_st <= ulbf_pkg::RX_IDLE;
      st_r.tx_data <= `ULBF_DATA_INIT;
      st_r.rx_data <= `ULBF_DATA_INIT;
      st_r.tx_lvl <= 1'b1;
      st_r.tx_line <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tx_line = st_r.tx_line;
  assign rx_data_reg = st_r.rx_data;
  assign break_tx_active = st_r.brk_tx_act;
  assign break_rx_active = st_r.brk_rx_act;
  assign break_rx_ok_flag = st_r.brk_ok;
  assign overrun_flag = st_r.ovr;
  assign parity_err_flag = st_r.perr;
  assign framing_err_flag = st_r.ferr;
  assign tx_irq = st_r.tx_irq;
  assign rx_irq = st_r.rx_irq;
  assign status_irq = st_r.st_irq;
endmodule

`default_nettype wire

// >>> tb/ulbf_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module ulbf_core_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic power_on,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic tx_level_invert,
  input wire logic tx_irq_timing,
  input wire logic [2:0] break_len_sel,
  input wire logic [11:0] baud_divisor,
  input wire logic break_ok_clear,
  input wire logic tx_line,
  input wire logic [7:0] rx_data_reg,
  input wire logic break_tx_active,
  input wire logic break_rx_active,
  input wire logic break_rx_ok_flag,
  input wire logic overrun_flag,
  input wire logic parity_err_flag,
  input wire logic framing_err_flag,
  input wire logic tx_irq,
  input wire logic status_irq
);
  logic [15:0] brk_cnt_r;
  logic [15:0] brk_cnt_nxt;
  always_comb begin
    brk_cnt_nxt = break_tx_active ? brk_cnt_r + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clock) begin
    brk_cnt_r <= rst ? 16'h0000 : brk_cnt_nxt;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_brk_start;
    $rose(break_tx_active);
  endsequence
  // An abort also drops the status, so only a powered, enabled end counts as done.
  sequence s_brk_done;
    $fell(break_tx_active) ##0 $past(power_on && tx_enable);
  endsequence
  a_brk_tx_low: assert property (break_tx_active |-> tx_line == tx_level_invert)
    else $error("break output not low");
  a_brk_tx_len: assert property (s_brk_done |->
    brk_cnt_r == (16'h000D + break_len_sel) * baud_divisor)
    else $error("break length wrong");
  a_brk_irq_start: assert property (s_brk_start |-> tx_irq == !tx_irq_timing)
    else $error("break start interrupt wrong");
  a_brk_irq_end: assert property (s_brk_done |-> tx_irq == tx_irq_timing)
    else $error("break end interrupt wrong");
  a_tx_off_abort: assert property (!(power_on && tx_enable) |=>
    !break_tx_active && tx_line == !$past(tx_level_invert))
    else $error("break transmit not aborted");
  a_rx_off_abort: assert property (!(power_on && rx_enable) |=> !break_rx_active)
    else $error("break receive not aborted");
  a_brk_ok_irq: assert property ($rose(break_rx_ok_flag) |->
    status_irq && !break_rx_active)
    else $error("break success without status event");
  a_ok_clear: assert property (break_ok_clear ##1 !status_irq |-> !break_rx_ok_flag)
    else $error("success flag not cleared");
  a_brk_no_err: assert property (break_rx_active |=>
    !$rose(overrun_flag || parity_err_flag || framing_err_flag))
    else $error("error flag during break wait");
  a_brk_rx_hold: assert property (break_rx_active && power_on |=> $stable(rx_data_reg))
    else $error("receive data changed during break wait");
endmodule
bind ulbf_core ulbf_core_props ulbf_core_props_inst (.clock(clock), .rst(rst),
  .power_on(power_on), .tx_enable(tx_enable), .rx_enable(rx_enable),
  .tx_level_invert(tx_level_invert), .tx_irq_timing(tx_irq_timing),
  .break_len_sel(break_len_sel), .baud_divisor(baud_divisor),
  .break_ok_clear(break_ok_clear), .tx_line(tx_line), .rx_data_reg(rx_data_reg),
  .break_tx_active(break_tx_active), .break_rx_active(break_rx_active),
  .break_rx_ok_flag(break_rx_ok_flag), .overrun_flag(overrun_flag),
  .parity_err_flag(parity_err_flag), .framing_err_flag(framing_err_flag),
  .tx_irq(tx_irq), .status_irq(status_irq));
`default_nettype wire

// >>> tb/ulbf_lin_node.sv
`timescale 1ns/1ps
`default_nettype none
module ulbf_lin_node (
  input wire logic clock,
  input wire logic inv,
  output logic line
);
  int div = 8;
  logic lvl = 1'h1;
  // The bus is pulled up between frames, so a released line reads recessive.
  assign line = lvl ^ inv;
  task automatic send(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      lvl <= v[i];
      repeat (div - 1) @(posedge clock);
    end
    @(posedge clock);
    lvl <= 1'h1;
  endtask
endmodule
`default_nettype wire

// >>> tb/ulbf_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ulbf_core_tb;
  localparam int D = 8;
  logic clock = 1'h0, rst = 1'h1, power_on = 1'h0, tx_enable = 1'h0, rx_enable = 1'h0;
  logic char_len_sel = 1'h1, stop_len_sel = 1'h0, bit_order_sel = 1'h1, tx_irq_timing = 1'h0;
  logic tx_level_invert = 1'h0, rx_level_invert = 1'h0, break_rx_mode = 1'h0;
  logic [4:0] pls = 5'h00;
  logic [1:0] parity_sel = 2'h0;
  logic [2:0] break_len_sel = 3'h0;
  logic [11:0] baud_divisor = 12'h008;
  logic [7:0] tx_data_in = 8'h00, last = 8'hFF, rx_data_reg;
  logic [7:0] exp_q[$];
  logic rx_line, tx_line, break_tx_active, break_rx_active, break_rx_ok_flag;
  logic overrun_flag, parity_err_flag, framing_err_flag, tx_irq, rx_irq, status_irq;
  int n_fail = 0, checks = 0, n_rx = 0, n_st = 0, n_tx = 0, w = 0, seed = 32'h3cef;
  ulbf_core ulbf_core_inst (.clock(clock), .rst(rst), .power_on(power_on),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .char_len_sel(char_len_sel),
    .parity_sel(parity_sel), .stop_len_sel(stop_len_sel), .bit_order_sel(bit_order_sel),
    .tx_level_invert(tx_level_invert), .rx_level_invert(rx_level_invert),
    .break_len_sel(break_len_sel), .baud_divisor(baud_divisor),
    .tx_irq_timing(tx_irq_timing), .break_rx_mode(break_rx_mode),
    .break_tx_trigger(pls[0]), .break_rx_trigger(pls[1]), .break_ok_clear(pls[2]),
    .err_clear(1'h0), .tx_data_wr(pls[4]), .tx_data_in(tx_data_in),
    .rx_data_read(pls[3]), .rx_line(rx_line), .tx_line(tx_line),
    .rx_data_reg(rx_data_reg), .break_tx_active(break_tx_active),
    .break_rx_active(break_rx_active), .break_rx_ok_flag(break_rx_ok_flag),
    .overrun_flag(overrun_flag), .parity_err_flag(parity_err_flag),
    .framing_err_flag(framing_err_flag), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .status_irq(status_irq));
  ulbf_lin_node ulbf_lin_node_inst (.clock(clock), .inv(rx_level_invert), .line(rx_line));
  initial forever #10 clock = ~clock;
  always @(posedge clock) begin
    n_rx += (rx_irq === 1'h1);
    n_st += (status_irq === 1'h1);
    n_tx += (tx_irq === 1'h1);
  end
  task automatic report_and_stop;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge clock);
    pls <= m;
    @(posedge clock);
    pls <= 5'h00;
  endtask
  // Reference frame, first bit in v[0], before any line inversion.
  function automatic int frame(input logic [7:0] d, output logic [15:0] v);
    int n;
    logic p;
    n = 1;
    p = 1'h0;
    v = 16'hFFFE;
    for (int i = 0; i < (char_len_sel ? 8 : 7); i++) begin
      v[n] = bit_order_sel ? d[i] : d[7 - i];
      p = p ^ v[n];
      n++;
    end
    if (parity_sel != 2'h0) begin
      v[n] = (parity_sel == 2'h1) ? 1'h0 : p ^ (parity_sel == 2'h2);
      n++;
    end
    return n + (stop_len_sel ? 2 : 1);
  endfunction
  task automatic duplex(input logic [7:0] dt, input logic [7:0] dr);
    logic [15:0] vt;
    logic [15:0] vr;
    int nt;
    int nr;
    tx_data_in <= dt;
    pulse(5'h10);
    nt = frame(dt, vt);
    nr = frame(dr, vr);
    w = n_rx;
    fork
      ulbf_lin_node_inst.send(vr, nr);
      begin
        repeat (D / 2 + 2) @(posedge clock);
        for (int i = 0; i < nt; i++) begin
          chk(tx_line, vt[i] ^ tx_level_invert);
          repeat (D) @(posedge clock);
        end
      end
    join
    repeat (D) @(posedge clock);
    exp_q.push_back(char_len_sel ? dr : bit_order_sel ? {1'h0, dr[6:0]} : {dr[7:1], 1'h0});
    last = exp_q[$];
    chk(n_rx - w, 1);
    chk(rx_data_reg, exp_q.pop_front());
    pulse(5'h08);
  endtask
  task automatic brk_tx(input logic [2:0] sel, input logic tm);
    int n;
    w = n_tx;
    break_len_sel <= sel;
    tx_irq_timing <= tm;
    pulse(5'h01);
    n = 0;
    repeat (2) @(posedge clock);
    while (break_tx_active === 1'h1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    chk(n, (13 + sel) * D);
    repeat (3 * D) @(posedge clock);
    chk(n_tx - w, 1);
    chk(tx_line, !tx_level_invert);
  endtask
  task automatic low_bits(input int n);
    ulbf_lin_node_inst.send(16'h0000, n);
    repeat (2 * D) @(posedge clock);
  endtask
  initial begin
    #(20 * 30000);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    power_on <= 1'h1;
    tx_enable <= 1'h1;
    rx_enable <= 1'h1;
    repeat (4) @(posedge clock);
    chk(tx_line, 1'h1);
    chk(rx_data_reg, 8'hFF);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      {char_len_sel, stop_len_sel, bit_order_sel} <= 3'($random(seed));
      {tx_level_invert, rx_level_invert} <= 2'($random(seed));
      parity_sel <= 2'(k);
      duplex(8'($random(seed)), 8'($random(seed)));
    end
    $display("test frames done");
    brk_tx(3'h0, 1'h0);
    brk_tx(3'h7, 1'h1);
    brk_tx(3'($random(seed)), 1'h0);
    tx_enable <= 1'h0;
    pulse(5'h01);
    repeat (4) @(posedge clock);
    chk(break_tx_active, 1'h0);
    tx_enable <= 1'h1;
    pulse(5'h01);
    repeat (30) @(posedge clock);
    chk(break_tx_active, 1'h1);
    tx_enable <= 1'h0;
    repeat (2) @(posedge clock);
    chk(break_tx_active, 1'h0);
    tx_enable <= 1'h1;
    $display("test break transmit done");
    pulse(5'h02);
    repeat (2) @(posedge clock);
    chk(break_rx_active, 1'h1);
    w = n_rx;
    low_bits(10);
    chk(n_rx - w, 0);
    chk(break_rx_active, 1'h1);
    low_bits(12);
    chk(n_rx - w, 1);
    chk(break_rx_active, 1'h0);
    break_rx_mode <= 1'h1;
    pulse(5'h02);
    w = n_st;
    for (int j = 0; j < 2; j++) begin
      low_bits(12);
      chk(n_st - w, j + 1);
      chk(break_rx_ok_flag, 1'h1);
      chk({overrun_flag, parity_err_flag, framing_err_flag}, 3'h0);
      pulse(5'h04);
      @(posedge clock);
      chk(break_rx_ok_flag, 1'h0);
    end
    chk(rx_data_reg, last);
    pulse(5'h02);
    rx_enable <= 1'h0;
    repeat (2) @(posedge clock);
    chk(break_rx_active, 1'h0);
    rx_enable <= 1'h1;
    pulse(5'h02);
    power_on <= 1'h0;
    repeat (2) @(posedge clock);
    chk(break_rx_active, 1'h0);
    chk(rx_data_reg, 8'hFF);
    $display("test break receive done");
    report_and_stop();
  end
endmodule
`default_nettype wire
